// File: lmq_map.svh
// Purpose: Register offsets, widths and reset values of the queue register bank
// Assumes: 32-bit aligned word accesses, byte offsets as printed
// Notes:   Definitions only
`ifndef LMQ_MAP_SVH
`define LMQ_MAP_SVH
`define LMQ_OFF_VERSION     12'h004
`define LMQ_OFF_PAGE_BYTES  12'h028
`define LMQ_OFF_SELECT      12'h030
`define LMQ_OFF_CAPACITY    12'h034
`define LMQ_OFF_LENGTH      12'h038
`define LMQ_OFF_BOUNDARY    12'h03c
`define LMQ_OFF_FRAME       12'h040
`define LMQ_OFF_DOORBELL    12'h050
`define LMQ_OFF_PENDING     12'h060
`define LMQ_OFF_CLEAR       12'h064
`define LMQ_OFF_PROGRESS    12'h070
`define LMQ_OFF_DEV_SPACE   12'h100
`define LMQ_VERSION_VALUE   32'h0000_0001
`define LMQ_ZERO_WORD       32'h0000_0000
`define LMQ_EVENT_BITS      2
`define LMQ_DOORBELL_BITS   16
`define LMQ_DEF_PAGE_BYTES  32'h0000_1000
`endif

// File: lmq_pkg.sv
// Purpose: Types shared by the queue register bank
// Assumes: lmq_map.svh holds offsets and values; bus field widths are written out here
// Notes:   Bus request travels as one packed struct
`include "lmq_map.svh"
package lmq_pkg;
    typedef struct packed {
        logic        req;
        logic        wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } lmq_bus_req_s;

    typedef struct packed {
        logic        rvalid;
        logic [31:0] rdata;
    } lmq_bus_rsp_s;

    typedef struct packed {
        logic [31:0] length;
        logic [31:0] boundary;
        logic [31:0] frame;
    } lmq_ring_cfg_s;

    typedef enum logic [1:0] {
        LMQ_RUN   = 2'b00,
        LMQ_RESET = 2'b01
    } lmq_state_e;
endpackage

// File: lmq_ring_store.sv
// Purpose: Per-queue storage of length, boundary and frame settings
// Assumes: One write port, one selected-read port, synchronous inputs
// Notes:   Frame of every queue cleared by wipe_i
`timescale 1ns/1ps
`include "lmq_map.svh"
module lmq_ring_store #(
    parameter int NUM_RINGS = 4,
    parameter int SEL_W     = 2
) (
    // Clock and reset
    input  wire logic                  clock_i,
    input  wire logic                  rstn_i,
    input  wire logic                  ce_i,
    // Control
    input  wire logic [SEL_W-1:0]      sel_i,
    input  wire logic                  wr_length_i,
    input  wire logic                  wr_boundary_i,
    input  wire logic                  wr_frame_i,
    input  wire logic [31:0]           wdata_i,
    input  wire logic                  wipe_i,
    // Selected settings
    output lmq_pkg::lmq_ring_cfg_s     cfg_o
);
    import lmq_pkg::*;

    lmq_ring_cfg_s mem_reg [NUM_RINGS];

    ////////////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < NUM_RINGS; g++) begin : g_ring
            always_ff @(posedge clock_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    mem_reg[g] <= '0;
                end else if (ce_i) begin
                    if (wipe_i) begin
                        mem_reg[g].frame <= `LMQ_ZERO_WORD;
                    end else if (sel_i == SEL_W'(g)) begin
                        if (wr_length_i) mem_reg[g].length <= wdata_i;
                        if (wr_boundary_i) mem_reg[g].boundary <= wdata_i;
                        if (wr_frame_i) mem_reg[g].frame <= wdata_i;
                    end
                end
            end
        end
    endgenerate

    assign cfg_o = mem_reg[sel_i];

    ////////////////////////////////////////////////////////////////////////////
    // Checks; write-only words are otherwise never looked at
    a_length_store: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        ce_i && !wipe_i && wr_length_i |=> cfg_o.length == $past(wdata_i))
        else $error("length write lost");
    a_boundary_store: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        ce_i && !wipe_i && wr_boundary_i |=> cfg_o.boundary == $past(wdata_i))
        else $error("boundary write lost");
endmodule

// File: lmq_page_addr.sv
// Purpose: Guest address of a queue's first page
// Assumes: Page size a power of two; other sizes still multiply
// Notes:   Registered product, one cycle late
`timescale 1ns/1ps
module lmq_page_addr (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rstn_i,
    input  wire logic        ce_i,
    // Operands
    input  wire logic [31:0] frame_i,
    input  wire logic [31:0] page_bytes_i,
    // Result
    output logic      [63:0] addr_o
);
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            addr_o <= 64'h0;
        end else if (ce_i) begin
            addr_o <= 64'(frame_i) * 64'(page_bytes_i);
        end
    end
endmodule

// File: lmq_regs.sv
// Purpose: Legacy memory-mapped queue register bank
// Assumes: Word accesses only; read data one cycle after request
// Notes:   Device-specific space reads zero here
//
// Function
// - First page address is frame times page
// - Selector picks queue for later accesses
// - Capacity read gives limit or zero
// - Length write stored for selected queue
// - Boundary write stored, power of two; the code stores any value written, unchecked
// - Frame write stored for selected queue
// - Frame read returns selected frame
// - Status read flags, nonzero write sets
// - Status zero write resets device
// - Reset clears every queue frame
// - Version register reads one
// - Event bits held until acknowledged or device reset
// - Interrupt output while any bit set
`timescale 1ns/1ps
`include "lmq_map.svh"
module lmq_regs #(
    parameter int          NUM_RINGS = 4,
    parameter int          SEL_W     = 2,
    parameter logic [31:0] RING_MAX  = 32'h0000_0100
) (
    // Clock and reset
    input  wire logic                              clock_i,
    input  wire logic                              rstn_i,
    input  wire logic                              ce_i,
    // Register access
    input  lmq_pkg::lmq_bus_req_s                  bus_i,
    output lmq_pkg::lmq_bus_rsp_s                  bus_o,
    // Device events
    input  wire logic [`LMQ_EVENT_BITS-1:0]        event_i,
    output logic                                   irq_o,
    // Doorbell to the queue engine
    output logic                                   bell_o,
    output logic [`LMQ_DOORBELL_BITS-1:0]          bell_index_o,
    // Selected queue location and device reset
    output logic [63:0]                            ring_addr_o,
    output logic                                   ring_active_o,
    output logic                                   dev_reset_o
);
    import lmq_pkg::*;

    lmq_state_e        state_reg;
    logic [31:0]       page_bytes_reg;
    logic [SEL_W-1:0]  sel_reg;
    logic [31:0]       progress_reg;
    logic [`LMQ_EVENT_BITS-1:0] pending_reg;
    lmq_ring_cfg_s     cfg;
    logic              wipe;
    logic [31:0]       rdata_next;
    logic              sel_ok;
    logic [31:0]       frame_sel;

    function automatic logic hit(input lmq_bus_req_s b, input logic w, input logic [11:0] off);
        hit = b.req && (b.wr == w) && (b.addr == off);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Device reset sequencing
    assign wipe = (state_reg == LMQ_RESET);

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= LMQ_RUN;
        end else if (ce_i) begin
            case (state_reg)
                LMQ_RUN: begin
                    if (hit(bus_i, 1'b1, `LMQ_OFF_PROGRESS) && bus_i.wdata == `LMQ_ZERO_WORD) begin
                        state_reg <= LMQ_RESET;
                    end
                end
                LMQ_RESET: begin
                    state_reg <= LMQ_RUN;
                end
                default: begin
                    state_reg <= LMQ_RUN;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Global registers
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            page_bytes_reg <= `LMQ_DEF_PAGE_BYTES;
        end else if (ce_i && hit(bus_i, 1'b1, `LMQ_OFF_PAGE_BYTES)) begin
            page_bytes_reg <= bus_i.wdata;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sel_reg <= '0;
        end else if (ce_i && hit(bus_i, 1'b1, `LMQ_OFF_SELECT)) begin
            sel_reg <= bus_i.wdata[SEL_W-1:0];
        end
    end

    // Selector values beyond the stored range read as unavailable
    assign sel_ok = (bus_i.wdata >> SEL_W) == 32'h0;
    logic sel_ok_reg;
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sel_ok_reg <= 1'b1;
        end else if (ce_i && hit(bus_i, 1'b1, `LMQ_OFF_SELECT)) begin
            sel_ok_reg <= sel_ok;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            progress_reg <= `LMQ_ZERO_WORD;
        end else if (ce_i && hit(bus_i, 1'b1, `LMQ_OFF_PROGRESS)) begin
            // Zero write clears, otherwise flags accumulate
            if (bus_i.wdata == `LMQ_ZERO_WORD) begin
                progress_reg <= `LMQ_ZERO_WORD;
            end else begin
                progress_reg <= progress_reg | bus_i.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event flags: a new event wins over a same-cycle acknowledge
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pending_reg <= '0;
        end else if (ce_i) begin
            if (wipe) begin
                pending_reg <= event_i;
            end else if (hit(bus_i, 1'b1, `LMQ_OFF_CLEAR)) begin
                pending_reg <= (pending_reg & ~bus_i.wdata[`LMQ_EVENT_BITS-1:0]) | event_i;
            end else begin
                pending_reg <= pending_reg | event_i;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_o <= |pending_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Doorbell
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bell_o       <= 1'b0;
            bell_index_o <= '0;
        end else if (ce_i) begin
            bell_o <= hit(bus_i, 1'b1, `LMQ_OFF_DOORBELL);
            if (hit(bus_i, 1'b1, `LMQ_OFF_DOORBELL)) begin
                bell_index_o <= bus_i.wdata[`LMQ_DOORBELL_BITS-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-queue settings
    lmq_ring_store #(
        .NUM_RINGS (NUM_RINGS),
        .SEL_W     (SEL_W)
    ) u_store (
        .clock_i       (clock_i),
        .rstn_i        (rstn_i),
        .ce_i          (ce_i),
        .sel_i         (sel_reg),
        .wr_length_i   (hit(bus_i, 1'b1, `LMQ_OFF_LENGTH) && sel_ok_reg),
        .wr_boundary_i (hit(bus_i, 1'b1, `LMQ_OFF_BOUNDARY) && sel_ok_reg),
        .wr_frame_i    (hit(bus_i, 1'b1, `LMQ_OFF_FRAME) && sel_ok_reg),
        .wdata_i       (bus_i.wdata),
        .wipe_i        (wipe),
        .cfg_o         (cfg)
    );

    // Unavailable queue yields no address rather than another queue's
    assign frame_sel = sel_ok_reg ? cfg.frame : `LMQ_ZERO_WORD;

    lmq_page_addr u_addr (
        .clock_i      (clock_i),
        .rstn_i       (rstn_i),
        .ce_i         (ce_i),
        .frame_i      (frame_sel),
        .page_bytes_i (page_bytes_reg),
        .addr_o       (ring_addr_o)
    );

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ring_active_o <= 1'b0;
            dev_reset_o   <= 1'b0;
        end else if (ce_i) begin
            ring_active_o <= sel_ok_reg && (cfg.frame != `LMQ_ZERO_WORD);
            dev_reset_o   <= wipe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path; write-only and unmapped words read zero
    always_comb begin
        rdata_next = `LMQ_ZERO_WORD;
        case (bus_i.addr)
            `LMQ_OFF_VERSION:  rdata_next = `LMQ_VERSION_VALUE;
            `LMQ_OFF_CAPACITY: rdata_next = sel_ok_reg ? RING_MAX : `LMQ_ZERO_WORD;
            `LMQ_OFF_FRAME:    rdata_next = sel_ok_reg ? cfg.frame : `LMQ_ZERO_WORD;
            `LMQ_OFF_PENDING:  rdata_next = 32'(pending_reg);
            `LMQ_OFF_PROGRESS: rdata_next = progress_reg;
            default:           rdata_next = `LMQ_ZERO_WORD;
        endcase
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_o <= '0;
        end else if (ce_i) begin
            bus_o.rvalid <= bus_i.req && !bus_i.wr;
            bus_o.rdata  <= (bus_i.req && !bus_i.wr) ? rdata_next : `LMQ_ZERO_WORD;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    a_zero_status_wipe: assert property (
        ce_i && !wipe && hit(bus_i, 1'b1, `LMQ_OFF_PROGRESS) && bus_i.wdata == `LMQ_ZERO_WORD
        |=> wipe)
        else $error("zero status write did not reset");
    a_wipe_clears_frame: assert property (
        wipe && ce_i
        |=> cfg.frame == `LMQ_ZERO_WORD)
        else $error("frame not cleared by reset");
    a_version_one: assert property (
        ce_i && bus_i.req && !bus_i.wr && bus_i.addr == `LMQ_OFF_VERSION
        |=> bus_o.rdata == `LMQ_VERSION_VALUE)
        else $error("version not one");
    a_event_held: assert property (
        ce_i && !wipe && !hit(bus_i, 1'b1, `LMQ_OFF_CLEAR) && pending_reg[0]
        |=> pending_reg[0])
        else $error("event bit dropped without ack");
    a_irq_follows: assert property (
        ce_i && |pending_reg
        |=> irq_o)
        else $error("interrupt not raised");
    a_capacity_value: assert property (
        ce_i && bus_i.req && !bus_i.wr && bus_i.addr == `LMQ_OFF_CAPACITY && sel_ok_reg
        |=> bus_o.rdata == RING_MAX)
        else $error("capacity wrong");
    a_wo_reads_zero: assert property (
        ce_i && bus_i.req && !bus_i.wr && bus_i.addr == `LMQ_OFF_LENGTH
        |=> bus_o.rdata == `LMQ_ZERO_WORD)
        else $error("write-only read nonzero");
    a_frame_store: assert property (
        ce_i && !wipe && sel_ok_reg && hit(bus_i, 1'b1, `LMQ_OFF_FRAME)
        |=> cfg.frame == $past(bus_i.wdata))
        else $error("frame write lost");
    a_status_sets: assert property (
        ce_i && hit(bus_i, 1'b1, `LMQ_OFF_PROGRESS) && bus_i.wdata != `LMQ_ZERO_WORD
        |=> (progress_reg & $past(bus_i.wdata)) == $past(bus_i.wdata))
        else $error("status flags not set");
    a_unavail_zero: assert property (
        ce_i && bus_i.req && !bus_i.wr && bus_i.addr == `LMQ_OFF_CAPACITY && !sel_ok_reg
        |=> bus_o.rdata == `LMQ_ZERO_WORD)
        else $error("unavailable queue capacity nonzero");
    a_ack_clears: assert property (
        ce_i && !wipe && hit(bus_i, 1'b1, `LMQ_OFF_CLEAR) && bus_i.wdata[0] && !event_i[0]
        |=> !pending_reg[0])
        else $error("acknowledged event bit still set");
    a_irq_quiet: assert property (
        ce_i && !(|pending_reg)
        |=> !irq_o)
        else $error("interrupt raised with nothing pending");
    a_bell_index: assert property (
        ce_i && hit(bus_i, 1'b1, `LMQ_OFF_DOORBELL)
        |=> bell_o && bell_index_o == $past(bus_i.wdata[`LMQ_DOORBELL_BITS-1:0]))
        else $error("doorbell index lost");
    a_ring_addr: assert property (
        ce_i
        |=> ring_addr_o == 64'($past(frame_sel)) * 64'($past(page_bytes_reg)))
        else $error("queue address wrong");
    a_ro_ignored: assert property (
        ce_i && !wipe && hit(bus_i, 1'b1, `LMQ_OFF_CAPACITY)
        |=> cfg.frame == $past(cfg.frame))
        else $error("read-only write changed a queue");
    c_reset_seen: cover property (wipe);
    c_irq_ack: cover property (irq_o ##1 hit(bus_i, 1'b1, `LMQ_OFF_CLEAR));
    c_bell: cover property (bell_o);
    c_active: cover property (ring_active_o);
endmodule

// File: lmq_drv_model.sv
// Purpose: Guest driver model issuing word reads and writes
// Assumes: Inputs change at the falling edge, one-cycle requests
// Notes:   Idle address and data are inverted so nothing leans on stale values
`timescale 1ns/1ps
module lmq_drv_model (
    // Clock
    input  wire logic             clock_i,
    // Register access
    output lmq_pkg::lmq_bus_req_s bus_o,
    input  lmq_pkg::lmq_bus_rsp_s bus_i
);
    import lmq_pkg::*;

    initial bus_o = '0;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge clock_i);
        bus_o = '{req: 1'b1, wr: 1'b1, addr: a, wdata: d};
        @(negedge clock_i);
        bus_o = '{req: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // Answer is taken only with rvalid; a missing answer reads unknown
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        int n;
        @(negedge clock_i);
        bus_o = '{req: 1'b1, wr: 1'b0, addr: a, wdata: 32'hffff_ffff};
        @(negedge clock_i);
        bus_o = '{req: 1'b0, wr: 1'b1, addr: ~a, wdata: 32'h0000_0000};
        for (n = 0; n < 3 && bus_i.rvalid !== 1'b1; n++) @(negedge clock_i);
        d = (bus_i.rvalid === 1'b1) ? bus_i.rdata : 32'hxxxx_xxxx;
    endtask
endmodule

// File: lmq_regs_tb.sv
// Purpose: Self-checking bench of the queue register bank
// Assumes: Driver model moves words, bench keeps the expected state
// Notes:   Status writes grow as supersets so set and replace agree
`timescale 1ns/1ps
`include "lmq_map.svh"
module lmq_regs_tb;
    import lmq_pkg::*;
    localparam int          NQ  = 4;
    localparam logic [31:0] CAP = 32'h0000_0100;

    logic         clock_i;
    logic         rstn_i;
    logic         ce_i;
    lmq_bus_req_s bus_req;
    lmq_bus_rsp_s bus_rsp;
    logic [1:0]   event_i;
    logic         irq_o;
    logic         bell_o;
    logic [15:0]  bell_index_o;
    logic [63:0]  ring_addr_o;
    logic         ring_active_o;
    logic         dev_reset_o;
    integer       errors = 0;
    integer       total_checks = 0;
    integer       seed = 71775;
    integer       bells = 0;
    integer       resets = 0;
    logic [31:0]  m_frame [NQ];
    logic [31:0]  m_page;
    logic [31:0]  m_status;
    logic [31:0]  v;
    logic [31:0]  rv;
    int           q;

    lmq_regs #(.NUM_RINGS(NQ), .SEL_W(2), .RING_MAX(CAP)) dut (
        .clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce_i), .bus_i(bus_req), .bus_o(bus_rsp),
        .event_i(event_i), .irq_o(irq_o), .bell_o(bell_o), .bell_index_o(bell_index_o),
        .ring_addr_o(ring_addr_o), .ring_active_o(ring_active_o), .dev_reset_o(dev_reset_o));

    lmq_drv_model drv (.clock_i(clock_i), .bus_o(bus_req), .bus_i(bus_rsp));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    // Pulse counters look at the falling edge, where outputs have settled
    always @(negedge clock_i) begin
        if (bell_o === 1'b1) bells++;
        if (dev_reset_o === 1'b1) resets++;
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        drv.rd(a, rv);
        chk({32'h0, rv}, {32'h0, e});
    endtask

    task automatic pulse(input logic [1:0] e);
        @(negedge clock_i);
        event_i = e;
        @(negedge clock_i);
        event_i = 2'b00;
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Tests need well under a thousand cycles
    initial begin
        #200000;
        errors++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rstn_i = 1'b0;
        ce_i = 1'b1;
        event_i = 2'b00;
        m_status = 32'h0;
        repeat (20) @(negedge clock_i);
        rstn_i = 1'b1;
        rdchk(`LMQ_OFF_VERSION, `LMQ_VERSION_VALUE);
        rdchk(`LMQ_OFF_PAGE_BYTES, 32'h0);
        rdchk(`LMQ_OFF_SELECT, 32'h0);
        rdchk(`LMQ_OFF_LENGTH, 32'h0);
        rdchk(`LMQ_OFF_BOUNDARY, 32'h0);
        rdchk(`LMQ_OFF_DOORBELL, 32'h0);
        rdchk(`LMQ_OFF_CLEAR, 32'h0);
        // Page size first, a power of two
        m_page = 32'h1 << (8 + ($unsigned($random(seed)) % 6));
        drv.wr(`LMQ_OFF_PAGE_BYTES, m_page);
        // Queue four is past the last one and must read unavailable
        for (q = 0; q <= NQ; q++) begin
            drv.wr(`LMQ_OFF_SELECT, 32'(q));
            rdchk(`LMQ_OFF_FRAME, 32'h0);
            rdchk(`LMQ_OFF_CAPACITY, (q < NQ) ? CAP : 32'h0);
            drv.wr(`LMQ_OFF_LENGTH, 32'h10 << q);
            drv.wr(`LMQ_OFF_BOUNDARY, m_page);
            v = ($random(seed) & 32'h000f_ffff) | 32'h1;
            drv.wr(`LMQ_OFF_FRAME, v);
            if (q < NQ) m_frame[q] = v;
            rdchk(`LMQ_OFF_FRAME, (q < NQ) ? v : 32'h0);
            chk({63'h0, ring_active_o}, (q < NQ) ? 64'h1 : 64'h0);
            chk(ring_addr_o, (q < NQ) ? {32'h0, v} * {32'h0, m_page} : 64'h0);
        end
        for (q = 0; q < NQ; q++) begin
            drv.wr(`LMQ_OFF_SELECT, 32'(q));
            rdchk(`LMQ_OFF_FRAME, m_frame[q]);
        end
        drv.wr(`LMQ_OFF_CAPACITY, $random(seed));
        drv.wr(`LMQ_OFF_VERSION, $random(seed));
        // Release the last queue; its capacity still reads the limit
        drv.wr(`LMQ_OFF_FRAME, 32'h0);
        m_frame[NQ-1] = 32'h0;
        rdchk(`LMQ_OFF_FRAME, m_frame[NQ-1]);
        rdchk(`LMQ_OFF_CAPACITY, CAP);
        rdchk(`LMQ_OFF_VERSION, `LMQ_VERSION_VALUE);
        for (q = 0; q < 3; q++) begin
            m_status = (m_status << 1) | 32'h1;
            drv.wr(`LMQ_OFF_PROGRESS, m_status);
            rdchk(`LMQ_OFF_PROGRESS, m_status);
        end
        // Enable low freezes state, so this write must not land
        @(negedge clock_i);
        ce_i = 1'b0;
        drv.wr(`LMQ_OFF_PROGRESS, 32'h8);
        ce_i = 1'b1;
        rdchk(`LMQ_OFF_PROGRESS, m_status);
        // Events held until the matching mask is written
        pulse(2'b01);
        rdchk(`LMQ_OFF_PENDING, 32'h1);
        chk({63'h0, irq_o}, 64'h1);
        pulse(2'b10);
        rdchk(`LMQ_OFF_PENDING, 32'h3);
        drv.wr(`LMQ_OFF_CLEAR, 32'h1);
        rdchk(`LMQ_OFF_PENDING, 32'h2);
        chk({63'h0, irq_o}, 64'h1);
        drv.wr(`LMQ_OFF_CLEAR, 32'h2);
        rdchk(`LMQ_OFF_PENDING, 32'h0);
        chk({63'h0, irq_o}, 64'h0);
        v = $random(seed);
        drv.wr(`LMQ_OFF_DOORBELL, v);
        repeat (2) @(negedge clock_i);
        chk({48'h0, bell_index_o}, {48'h0, v[15:0]});
        chk(64'(bells), 64'h1);
        // Reset by status zero with an event still pending
        pulse(2'b01);
        drv.wr(`LMQ_OFF_PROGRESS, 32'h0);
        repeat (4) @(negedge clock_i);
        chk(64'(resets), 64'h1);
        rdchk(`LMQ_OFF_PROGRESS, 32'h0);
        rdchk(`LMQ_OFF_PENDING, 32'h0);
        for (q = 0; q < NQ; q++) begin
            drv.wr(`LMQ_OFF_SELECT, 32'(q));
            rdchk(`LMQ_OFF_FRAME, 32'h0);
        end
        chk({63'h0, ring_active_o}, 64'h0);
        chk({63'h0, irq_o}, 64'h0);
        summarize();
    end
endmodule
